/* File: bank_switch_pkg.sv */
// Constants for the external bus bank-switch control block
`default_nettype none
package bank_switch_pkg;
    localparam logic [15:0] BANK_SWITCH_CONTROL_ADDR = 16'h0029;
    localparam logic [15:0] BANK_SWITCH_CONTROL_RESET = 16'hF800;
    localparam logic [15:0] BANK_SWITCH_CONTROL_WMASK = 16'hF807;
    localparam int          BANK_CMP_HI  = 15;
    localparam int          BANK_CMP_LO  = 12;
    localparam int          READ_GAP_BIT = 11;
    localparam int          HOST_HOLD_BIT = 2;
    localparam int          DATA_HOLD_BIT = 1;
    localparam int          BUS_OFF_BIT  = 0;
    localparam int          IO_ADDR_W    = 16;
    localparam int          DATA_W       = 16;
    localparam int          HOST_W       = 8;
    typedef enum logic [1:0] {
        SPACE_PROG,
        SPACE_DATA,
        SPACE_IO
    } space_e;
endpackage : bank_switch_pkg
`default_nettype wire

/* File: bank_switch_bus_control.sv */
// External bus control: bank-switch idle cycles, bus holders, bus-off, I/O strobe
`default_nettype none
module bank_switch_bus_control
    import bank_switch_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // Memory-mapped register port
    input  wire logic                 reg_write,
    input  wire logic [15:0]          reg_addr,
    input  wire logic [15:0]          reg_wdata,
    output logic      [15:0]          reg_rdata,
    // Core access request
    input  wire logic                 req_valid,
    input  wire logic [1:0]           req_space,
    input  wire logic                 req_write,
    input  wire logic [15:0]          req_addr,
    input  wire logic [DATA_W-1:0]    req_wdata,
    output logic                      req_ready,
    output logic      [DATA_W-1:0]    req_rdata,
    output logic                      req_done,
    // Mode bit change requests from core
    input  wire logic                 mode_write,
    input  wire logic [3:0]           mode_wdata,
    output logic      [3:0]           mode_bits,
    output logic                      mode_blocked,
    // External parallel bus
    output logic      [15:0]          ext_addr,
    output logic      [DATA_W-1:0]    ext_data_out,
    output logic                      ext_data_oe,
    input  wire logic [DATA_W-1:0]    ext_data_in,
    output logic                      prog_strobe_n,
    output logic                      data_strobe_n,
    output logic                      io_space_strobe_n,
    output logic                      ext_read_write,
    output logic                      ext_bus_idle,
    // Host data bus holder
    input  wire logic [HOST_W-1:0]    host_data_bus_in,
    input  wire logic                 host_data_driven,
    output logic      [HOST_W-1:0]    host_data_bus_out,
    output logic                      host_data_bus_oe,
    // Data bus holder input qualifier
    input  wire logic                 ext_data_driven
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_GAP,
        ST_ACCESS
    } bus_state_e;

    logic [15:0]       bank_switch_control;
    bus_state_e        state;
    logic [3:0]        prev_prog_bank;
    logic [3:0]        prev_data_bank;
    logic              prev_valid;
    logic [1:0]        prev_space;
    logic              prev_read;
    logic [1:0]        cur_space;
    logic              cur_write;
    logic [15:0]       cur_addr;
    logic [DATA_W-1:0] cur_wdata;
    logic [DATA_W-1:0] data_sync1;
    logic [DATA_W-1:0] data_sync2;
    logic              data_drv1;
    logic              data_drv2;
    logic [HOST_W-1:0] host_sync1;
    logic [HOST_W-1:0] host_sync2;
    logic              host_drv1;
    logic              host_drv2;
    logic [DATA_W-1:0] data_held;
    logic [HOST_W-1:0] host_held;

    logic [3:0] bank_mask;
    logic       bus_off;
    logic [3:0] new_bank;
    logic       bank_change;
    logic       space_cross;
    logic       read_gap;
    logic       need_gap;
    logic       data_hold_en;

    assign bank_mask = bank_switch_control[BANK_CMP_HI:BANK_CMP_LO];
    assign bus_off   = bank_switch_control[BUS_OFF_BIT];
    // Fewer mask bits give larger banks; history kept raw, masked at compare
    assign new_bank  = req_addr[15:12] & bank_mask;

    assign bank_change = prev_valid && (req_space == SPACE_PROG
                         ? new_bank != (prev_prog_bank & bank_mask)
                         : req_space == SPACE_DATA
                           && new_bank != (prev_data_bank & bank_mask));

    assign space_cross = prev_valid && prev_space == SPACE_DATA
                         && req_space == SPACE_PROG;
    assign read_gap    = bank_switch_control[READ_GAP_BIT] && prev_valid && prev_read
                         && !req_write
                         && ((prev_space == SPACE_PROG && req_space == SPACE_DATA)
                         || (prev_space == SPACE_DATA && req_space == SPACE_PROG));
    assign need_gap    = bank_change || space_cross || read_gap;
    assign data_hold_en = bank_switch_control[DATA_HOLD_BIT] && !data_drv2;

    // Register: reserved bits keep reset zero and read back as zero
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            bank_switch_control <= BANK_SWITCH_CONTROL_RESET;
        end
        else if (reg_write && reg_addr == BANK_SWITCH_CONTROL_ADDR)
        begin
            bank_switch_control <= reg_wdata & BANK_SWITCH_CONTROL_WMASK;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            reg_rdata <= 16'h0000;
        end
        else
        begin
            reg_rdata <= (reg_addr == BANK_SWITCH_CONTROL_ADDR)
                         ? bank_switch_control : 16'h0000;
        end
    end

    // Mode bits: ROM-in-data, micro mode, overlay, hold mode
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mode_bits    <= 4'h0;
            mode_blocked <= 1'b0;
        end
        else
        begin
            mode_blocked <= mode_write && bus_off;
            if (mode_write && !bus_off)
            begin
                mode_bits <= mode_wdata;
            end
        end
    end

    // Bus sequencer: a request is held off while bus-off is set
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state      <= ST_IDLE;
            cur_space  <= SPACE_PROG;
            cur_write  <= 1'b0;
            cur_addr   <= 16'h0000;
            cur_wdata  <= '0;
            req_ready  <= 1'b0;
            req_done   <= 1'b0;
            req_rdata  <= '0;
            prev_valid <= 1'b0;
            prev_space <= SPACE_PROG;
            prev_read  <= 1'b0;
            prev_prog_bank <= 4'h0;
            prev_data_bank <= 4'h0;
        end
        else
        begin
            req_ready <= 1'b0;
            req_done  <= 1'b0;
            unique case (state)
                ST_IDLE:
                begin
                    if (req_valid && !bus_off && !req_ready)
                    begin
                        req_ready <= 1'b1;
                        cur_space <= req_space;
                        cur_write <= req_write;
                        cur_addr  <= req_addr;
                        cur_wdata <= req_wdata;
                        prev_valid <= 1'b1;
                        prev_space <= req_space;
                        prev_read  <= !req_write;
                        if (req_space == SPACE_PROG)
                        begin
                            prev_prog_bank <= req_addr[15:12];
                        end
                        if (req_space == SPACE_DATA)
                        begin
                            prev_data_bank <= req_addr[15:12];
                        end
                        state <= need_gap ? ST_GAP : ST_ACCESS;
                    end
                end
                ST_GAP:
                begin
                    state <= ST_ACCESS;
                end
                ST_ACCESS:
                begin
                    // Cycle in progress always completes even if bus-off was set
                    req_done  <= 1'b1;
                    req_rdata <= ext_data_in;
                    state     <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // External pins inactive outside an access cycle, save the data holder
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ext_addr          <= 16'h0000;
            ext_data_out      <= '0;
            ext_data_oe       <= 1'b0;
            prog_strobe_n     <= 1'b1;
            data_strobe_n     <= 1'b1;
            io_space_strobe_n <= 1'b1;
            ext_read_write    <= 1'b1;
            ext_bus_idle      <= 1'b1;
        end
        else if (state == ST_GAP || (state == ST_IDLE && !(req_valid && !bus_off
                 && !req_ready && !need_gap)))
        begin
            prog_strobe_n     <= 1'b1;
            data_strobe_n     <= 1'b1;
            io_space_strobe_n <= 1'b1;
            ext_read_write    <= 1'b1;
            ext_data_oe       <= state == ST_IDLE ? data_hold_en : ext_data_oe;
            ext_data_out      <= data_hold_en ? data_held : ext_data_out;
            ext_bus_idle      <= 1'b1;
            if (bus_off && state == ST_IDLE)
            begin
                ext_addr     <= 16'h0000;
                ext_data_out <= data_hold_en ? data_held : '0;
            end
            if (state == ST_GAP)
            begin
                ext_addr       <= cur_addr;
                ext_data_out   <= cur_wdata;
                ext_data_oe    <= cur_write;
                ext_read_write <= !cur_write;
                ext_bus_idle   <= 1'b0;
                prog_strobe_n  <= !(cur_space == SPACE_PROG);
                data_strobe_n  <= !(cur_space == SPACE_DATA);
                io_space_strobe_n <= !(cur_space == SPACE_IO);
            end
        end
        else if (state == ST_IDLE)
        begin
            ext_addr          <= req_addr;
            ext_data_out      <= req_wdata;
            ext_data_oe       <= req_write;
            ext_read_write    <= !req_write;
            ext_bus_idle      <= 1'b0;
            prog_strobe_n     <= !(req_space == SPACE_PROG);
            data_strobe_n     <= !(req_space == SPACE_DATA);
            io_space_strobe_n <= !(req_space == SPACE_IO);
        end
        else
        begin
            prog_strobe_n     <= 1'b1;
            data_strobe_n     <= 1'b1;
            io_space_strobe_n <= 1'b1;
            ext_read_write    <= 1'b1;
            ext_data_oe       <= 1'b0;
            ext_bus_idle      <= 1'b1;
        end
    end

    // Pad synchronisers for the holders
    always_ff @(posedge clk_sys)
    begin
        data_sync1 <= ext_data_in;
        data_sync2 <= data_sync1;
        data_drv1  <= ext_data_driven;
        data_drv2  <= data_drv1;
        host_sync1 <= host_data_bus_in;
        host_sync2 <= host_sync1;
        host_drv1  <= host_data_driven;
        host_drv2  <= host_drv1;
    end

    // Holders track the last driven level; synchroniser delay is the trade-off
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            data_held <= '0;
            host_held <= '0;
        end
        else
        begin
            if (data_drv2)
            begin
                data_held <= data_sync2;
            end
            if (host_drv2)
            begin
                host_held <= host_sync2;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            host_data_bus_out <= '0;
            host_data_bus_oe  <= 1'b0;
        end
        else
        begin
            host_data_bus_out <= host_held;
            host_data_bus_oe  <= bank_switch_control[HOST_HOLD_BIT] && !host_drv2;
        end
    end

endmodule : bank_switch_bus_control
`default_nettype wire

/* File: bank_switch_properties.sv */
// Assertions on the bank-switch bus control ports
`default_nettype none
module bank_switch_properties
    import bank_switch_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        reg_write,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        req_ready,
    input wire logic        req_done,
    input wire logic        mode_write,
    input wire logic [3:0]  mode_wdata,
    input wire logic [3:0]  mode_bits,
    input wire logic        mode_blocked,
    input wire logic        prog_strobe_n,
    input wire logic        data_strobe_n,
    input wire logic        io_space_strobe_n,
    input wire logic        host_data_bus_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] shadow;
    logic        hi;
    assign hi = prog_strobe_n & data_strobe_n & io_space_strobe_n;
    // Local copy of the register, so no hierarchy is needed
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            shadow <= BANK_SWITCH_CONTROL_RESET;
        else if (reg_write && reg_addr == BANK_SWITCH_CONTROL_ADDR)
            shadow <= reg_wdata & BANK_SWITCH_CONTROL_WMASK;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    property p_gap_len;
        req_ready && hi |-> ##2 req_done;
    endproperty
    a_gap_len: assert property (p_gap_len) else $error("gap access length");
    property p_nogap_len;
        req_ready && !hi |-> ##1 req_done;
    endproperty
    a_nogap_len: assert property (p_nogap_len) else $error("plain access length");
    property p_io_excl;
        !io_space_strobe_n |-> prog_strobe_n && data_strobe_n;
    endproperty
    a_io_excl: assert property (p_io_excl) else $error("io strobe shared");
    property p_off_refuse;
        shadow[BUS_OFF_BIT] && $past(shadow[BUS_OFF_BIT]) |-> !req_ready;
    endproperty
    a_off_refuse: assert property (p_off_refuse) else $error("taken while off");
    property p_mode_block;
        mode_write && shadow[BUS_OFF_BIT] |=> mode_blocked && $stable(mode_bits);
    endproperty
    a_mode_block: assert property (p_mode_block) else $error("mode not blocked");
    property p_mode_take;
        mode_write && !shadow[BUS_OFF_BIT] |=> !mode_blocked && mode_bits == $past(mode_wdata);
    endproperty
    a_mode_take: assert property (p_mode_take) else $error("mode not taken");
    property p_reg_read;
        !reg_write && reg_addr == BANK_SWITCH_CONTROL_ADDR |=> reg_rdata == $past(shadow);
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("register readback");
    property p_host_off;
        !shadow[HOST_HOLD_BIT] && !$past(shadow[HOST_HOLD_BIT]) |-> !host_data_bus_oe;
    endproperty
    a_host_off: assert property (p_host_off) else $error("host holder on");
endmodule : bank_switch_properties
`default_nettype wire

/* File: ext_bus_memory.sv */
// External memory and I/O device model on the parallel bus
`default_nettype none
module ext_bus_memory
(
    input wire logic        clk_sys,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_data_out,
    input wire logic        sel_n,
    input wire logic        ext_read_write,
    output logic     [15:0] ext_data_in,
    output logic            ext_data_driven
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256];
    logic [15:0] last = 16'h0000;
    always_ff @(posedge clk_sys)
    begin
        if (!sel_n && !ext_read_write)
            mem[ext_addr[7:0]] <= ext_data_out;
        if (!sel_n)
            last <= ext_data_in;
    end
    // Released bus shows the inverse, so a stale value cannot pass
    assign ext_data_driven = !sel_n && ext_read_write;
    assign ext_data_in = ext_data_driven ? mem[ext_addr[7:0]] : ~last;
endmodule : ext_bus_memory
`default_nettype wire

/* File: bank_switch_bus_control_tb.sv */
// Self-checking bench for the bank-switch bus control block
`default_nettype none
module bank_switch_bus_control_tb
    import bank_switch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] cfg;
        logic [1:0]  sp;
        logic        w;
        logic [15:0] addr;
        logic        gap;
    } row_s;
    // Each row's gap depends on the access before it
    localparam row_s ROWS [16] = '{
        '{16'hF800, 2'h1, 1'b0, 16'h0010, 1'b0}, '{16'hF800, 2'h1, 1'b0, 16'h1010, 1'b1},
        '{16'hF800, 2'h1, 1'b1, 16'h1020, 1'b0}, '{16'hF800, 2'h0, 1'b0, 16'h0001, 1'b1},
        '{16'hF800, 2'h0, 1'b0, 16'h0002, 1'b0}, '{16'hF800, 2'h1, 1'b1, 16'h1030, 1'b0},
        '{16'hF800, 2'h0, 1'b0, 16'h0003, 1'b1}, '{16'hF800, 2'h2, 1'b1, 16'h80AB, 1'b0},
        '{16'hF800, 2'h2, 1'b0, 16'h80AB, 1'b0}, '{16'hF800, 2'h0, 1'b0, 16'h0004, 1'b0},
        '{16'hF800, 2'h1, 1'b0, 16'h1040, 1'b1}, '{16'h8000, 2'h0, 1'b0, 16'h1000, 1'b1},
        '{16'h8000, 2'h0, 1'b0, 16'h7000, 1'b0}, '{16'h8000, 2'h0, 1'b0, 16'h9000, 1'b1},
        '{16'h8000, 2'h1, 1'b0, 16'h1050, 1'b0}, '{16'h0000, 2'h1, 1'b0, 16'hF000, 1'b0}};
    logic        clk_sys, req_ready, req_done, mode_blocked, ext_data_oe, ext_data_driven;
    logic        prog_strobe_n, data_strobe_n, io_space_strobe_n, ext_read_write;
    logic        ext_bus_idle, host_data_bus_oe;
    logic        reset = 1'b1, reg_write = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic        mode_write = 1'b0, host_data_driven = 1'b0;
    logic [1:0]  req_space = 2'h0;
    logic [3:0]  mode_wdata = 4'h0, mode_bits;
    logic [7:0]  host_val = 8'h00, host_data_bus_in, host_data_bus_out;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, req_addr = 16'h0000;
    logic [15:0] req_wdata = 16'h0000, reg_rdata, req_rdata, ext_addr, ext_data_out;
    logic [15:0] ext_data_in, rdat, cfg = 16'hF800;
    logic [2:0]  seen;
    int          n_errors = 0, num_checks = 0, lat;
    // Host wire level: host side, else holder, else floating
    assign host_data_bus_in = host_data_driven ? host_val :
                              (host_data_bus_oe ? host_data_bus_out : ~host_val);
    bank_switch_bus_control u_dut (
        .clk_sys, .reset, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .req_valid, .req_space,
        .req_write, .req_addr, .req_wdata, .req_ready, .req_rdata, .req_done, .mode_write,
        .mode_wdata, .mode_bits, .mode_blocked, .ext_addr, .ext_data_out, .ext_data_oe,
        .ext_data_in, .prog_strobe_n, .data_strobe_n, .io_space_strobe_n, .ext_read_write,
        .ext_bus_idle, .host_data_bus_in, .host_data_driven, .host_data_bus_out,
        .host_data_bus_oe, .ext_data_driven);
    ext_bus_memory u_mem (.clk_sys, .ext_addr, .ext_data_out, .ext_read_write, .ext_data_in,
        .sel_n(prog_strobe_n & data_strobe_n & io_space_strobe_n), .ext_data_driven);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        reg_addr <= a;
        repeat (2) @(posedge clk_sys);
        check("register", reg_rdata, exp);
    endtask : rd
    task automatic mode_wr(input logic [3:0] v, input logic blk);
        mode_write <= 1'b1;
        mode_wdata <= v;
        @(posedge clk_sys);
        mode_write <= 1'b0;
        @(posedge clk_sys);
        check("blocked", 16'(mode_blocked), 16'(blk));
    endtask : mode_wr
    task automatic acc(input logic [1:0] sp, input logic w, input logic [15:0] a);
        int i;
        req_valid <= 1'b1;
        req_space <= sp;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= a ^ 16'h5A5A;
        lat = 0;
        for (i = 0; i < 20 && req_ready !== 1'b1; i++)
            @(posedge clk_sys);
        req_valid <= 1'b0;
        seen = {prog_strobe_n, data_strobe_n, io_space_strobe_n};
        if (req_ready === 1'b1)
            for (lat = 1; lat < 8 && req_done !== 1'b1; lat++)
            begin
                @(posedge clk_sys);
                seen &= {prog_strobe_n, data_strobe_n, io_space_strobe_n};
            end
        rdat = req_rdata;
    endtask : acc
    initial
    begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(BANK_SWITCH_CONTROL_ADDR, 16'hF800);
        acc(2'h0, 1'b0, 16'h0000);
        acc(2'h1, 1'b0, 16'h0000);
        foreach (ROWS[k])
        begin
            if (ROWS[k].cfg !== cfg)
                wr(BANK_SWITCH_CONTROL_ADDR, ROWS[k].cfg);
            cfg = ROWS[k].cfg;
            acc(ROWS[k].sp, ROWS[k].w, ROWS[k].addr);
            check("latency", 16'(lat), ROWS[k].gap ? 16'h0003 : 16'h0002);
            check("strobe", 16'(seen ^ (3'b100 >> ROWS[k].sp)), 16'h0007);
            if (ROWS[k].sp == 2'h2 && !ROWS[k].w)
                check("io data", rdat, ROWS[k].addr ^ 16'h5A5A);
        end
        wr(BANK_SWITCH_CONTROL_ADDR, 16'hFFFE);
        rd(BANK_SWITCH_CONTROL_ADDR, 16'hF806);
        rd(16'h002A, 16'h0000);
        host_data_driven <= 1'b1;
        host_val <= 8'h5A;
        repeat (4) @(posedge clk_sys);
        host_data_driven <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("hold on", 16'(host_data_bus_oe), 16'h0001);
        check("hold value", 16'(host_data_bus_out), 16'h005A);
        wr(BANK_SWITCH_CONTROL_ADDR, 16'hF800);
        repeat (4) @(posedge clk_sys);
        check("hold off", 16'(host_data_bus_oe), 16'h0000);
        wr(BANK_SWITCH_CONTROL_ADDR, 16'hF801);
        mode_wr(4'hA, 1'b1);
        check("mode kept", 16'(mode_bits), 16'h0000);
        acc(2'h0, 1'b0, 16'h0000);
        check("taken off", 16'(lat), 16'h0000);
        check("off addr", ext_addr, 16'h0000);
        check("off idle", 16'(ext_bus_idle), 16'h0001);
        wr(BANK_SWITCH_CONTROL_ADDR, 16'hF800);
        mode_wr(4'h5, 1'b0);
        check("mode", 16'(mode_bits), 16'h0005);
        wr(BANK_SWITCH_CONTROL_ADDR, 16'hF802);
        acc(2'h1, 1'b0, 16'h1020);
        check("data read", rdat, 16'h1020 ^ 16'h5A5A);
        repeat (4) @(posedge clk_sys);
        check("data hold on", 16'(ext_data_oe), 16'h0001);
        check("data hold value", ext_data_out, 16'h1020 ^ 16'h5A5A);
        wr(BANK_SWITCH_CONTROL_ADDR, 16'hF800);
        repeat (2) @(posedge clk_sys);
        check("data hold off", 16'(ext_data_oe), 16'h0000);
        print_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end
endmodule : bank_switch_bus_control_tb
bind bank_switch_bus_control bank_switch_properties u_props (
    .clk_sys, .reset, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .req_ready, .req_done,
    .mode_write, .mode_wdata, .mode_bits, .mode_blocked, .prog_strobe_n, .data_strobe_n,
    .io_space_strobe_n, .host_data_bus_oe);
`default_nettype wire
